// ==== logic/mac_pkg.sv ====
// Purpose: shared constants for the multiply-accumulate engine
// Assumes: byte-wide register port, one system clock
// Notes: register addresses are local choices, see hand-over
package mac_pkg;

    localparam int MAC_ADDR_W = 8;
    localparam int MAC_DATA_W = 8;
    localparam int MAC_OPND_W = 16;
    localparam int MAC_PROD_W = 32;
    localparam int MAC_ACC_W = 40;
    localparam int MAC_RND_W = 16;
    localparam int MAC_RSUM_W = 25;

    ////////////////////////////////////////////////////////////////////////
    // register addresses
    localparam logic [7:0] MAC_ADDR_CONFIG = 8'hd7;
    localparam logic [7:0] MAC_ADDR_STATUS = 8'hcf;
    localparam logic [7:0] MAC_ADDR_A_HIGH = 8'ha5;
    localparam logic [7:0] MAC_ADDR_A_LOW = 8'ha4;
    localparam logic [7:0] MAC_ADDR_B_HIGH = 8'hf2;
    localparam logic [7:0] MAC_ADDR_B_LOW = 8'hf1;
    localparam logic [7:0] MAC_ADDR_ACC_OVR = 8'h96;
    localparam logic [7:0] MAC_ADDR_ACC_B3 = 8'h95;
    localparam logic [7:0] MAC_ADDR_ACC_B2 = 8'h94;
    localparam logic [7:0] MAC_ADDR_ACC_B1 = 8'h93;
    localparam logic [7:0] MAC_ADDR_ACC_B0 = 8'h92;
    localparam logic [7:0] MAC_ADDR_RND_HIGH = 8'hce;
    localparam logic [7:0] MAC_ADDR_RND_LOW = 8'hcd;

    ////////////////////////////////////////////////////////////////////////
    // configuration bit positions
    localparam int MAC_CF_MS = 0;
    localparam int MAC_CF_FM = 1;
    localparam int MAC_CF_SAT = 2;
    localparam int MAC_CF_CA = 3;
    localparam int MAC_CF_SD = 4;
    localparam int MAC_CF_SC = 5;
    localparam int MAC_CF_W = 6;

    // status bit positions
    localparam int MAC_ST_N = 0;
    localparam int MAC_ST_SO = 1;
    localparam int MAC_ST_Z = 2;
    localparam int MAC_ST_HO = 3;
    localparam int MAC_ST_W = 4;

    ////////////////////////////////////////////////////////////////////////
    // reset values and data constants
    localparam logic [5:0] MAC_CF_RESET = 6'h00;
    localparam logic [3:0] MAC_ST_RESET = 4'h4;
    localparam logic [7:0] MAC_OVR_POS_TOP = 8'h7f;
    localparam logic [7:0] MAC_OVR_NEG_TOP = 8'h80;
    localparam logic [15:0] MAC_RND_HALF = 16'h8000;
    localparam logic [15:0] MAC_SAT_POS = 16'h7fff;
    localparam logic [15:0] MAC_SAT_NEG = 16'h8000;
    localparam int MAC_RND_LSB = 16;
    localparam int MAC_SIGN_BIT = 31;

endpackage : mac_pkg

// ==== logic/mac_engine.sv ====
// Purpose: 16x16 signed multiply-accumulate engine behind byte registers
// Assumes: core writes and reads the registers on clk_sys, no sync needed
// Notes: read data is registered, valid one cycle after the read strobe
`timescale 1ns/100ps

// Functional notes
// - integer mode: 16-bit signed operands give a 40-bit signed integer.
// - fractional mode: operand point after bit 15, accumulator after 31.
// - mac mode multiplies a by b and adds to the accumulator.
// - three pipeline stages, one system clock each.
// - writing b low byte starts an operation; software writes it last.
// - stage one forms the product, stage two adds and stores it.
// - status flags update at the end of stage two.
// - a new start is accepted during the previous stage one.
// - stage three loads the rounded, optionally saturated, result.
// - clear bit at start clears accumulator and flags, then self-clears.
// - multiply-only overwrites the accumulator, ready two clocks after.
// - multiply-only leaves the hard overflow flag unchanged.
// - shift bit shifts one clock, rounding one later, bit self-clears.
// - shift direction 0 shifts left, 1 shifts right.
// - right shift refills the top bit with old bit 39.
// - shifts never touch the status flags.
// - round bits 31-16 unbiased on the low half compared with 0x8000.
// - rounding recomputed at stage three, after shift, after byte0 write.
// - rounding never alters the accumulator; same in both modes.
// - saturation loads 0x7fff or 0x8000 on overflow when enabled.
// - accumulator is five software read and write byte registers.
// - rounding holds 16 low bits; negative flag gives the sign.
// - hard overflow on 0x7f to 0x80 or back; software or clear resets.
// - soft overflow set on overflow into bit 31, cleared when corrected.
// - zero flag follows an all-zero accumulator result.
// - negative flag follows the accumulator sign.
module mac_engine (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [mac_pkg::MAC_ADDR_W-1:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [mac_pkg::MAC_DATA_W-1:0] sfr_wdata,
    output logic [mac_pkg::MAC_DATA_W-1:0] sfr_rdata
);
    import mac_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // registers
    logic [MAC_CF_W-1:0] mac_configuration;
    logic [MAC_ST_W-1:0] mac_status_flags;
    logic [MAC_OPND_W-1:0] operand_a;
    logic [MAC_OPND_W-1:0] operand_b;
    logic [MAC_ACC_W-1:0] acc;
    logic [MAC_RND_W-1:0] rounding_result;

    // pipeline state
    logic s1_valid;
    logic s1_clr;
    logic s2_valid;
    logic s2_clr;
    logic s2_ms;
    logic [MAC_PROD_W:0] s2_prod;
    logic rnd_pending;

    logic wr_cf;
    logic wr_st;
    logic wr_bl;
    logic wr_acc0;
    logic shift_now;

    assign wr_cf = sfr_wr && (sfr_addr == MAC_ADDR_CONFIG);
    assign wr_st = sfr_wr && (sfr_addr == MAC_ADDR_STATUS);
    assign wr_bl = sfr_wr && (sfr_addr == MAC_ADDR_B_LOW);
    assign wr_acc0 = sfr_wr && (sfr_addr == MAC_ADDR_ACC_B0);
    assign shift_now = mac_configuration[MAC_CF_SC];

    ////////////////////////////////////////////////////////////////////////
    // stage one: product
    logic signed [MAC_PROD_W-1:0] raw_prod;
    logic [MAC_PROD_W:0] next_prod;

    assign raw_prod = $signed(operand_a) * $signed(operand_b);
    // one extra bit so the fractional doubling of -1 x -1 still fits
    always_comb begin
        if (mac_configuration[MAC_CF_FM]) begin
            next_prod = {raw_prod, 1'b0};
        end else begin
            next_prod = {raw_prod[MAC_PROD_W-1], raw_prod};
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            s1_valid <= 1'b0;
            s1_clr <= 1'b0;
            s2_valid <= 1'b0;
            s2_clr <= 1'b0;
            s2_ms <= 1'b0;
            s2_prod <= '0;
        end else begin
            s1_valid <= wr_bl;
            s1_clr <= wr_bl && mac_configuration[MAC_CF_CA];
            s2_valid <= s1_valid;
            s2_clr <= s1_clr;
            s2_ms <= mac_configuration[MAC_CF_MS];
            if (s1_valid) begin
                s2_prod <= next_prod;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // stage two: accumulate and flags
    logic [MAC_ACC_W-1:0] acc_base;
    logic [MAC_ACC_W-1:0] next_acc_sum;
    logic [MAC_ST_W-1:0] next_flags;
    logic ovr_wrap;

    always_comb begin
        // a clear still pending from this op's stage one forces zero base
        if (s2_ms || s2_clr) begin
            acc_base = '0;
        end else begin
            acc_base = acc;
        end
        next_acc_sum = acc_base +
            {{(MAC_ACC_W-MAC_PROD_W-1){s2_prod[MAC_PROD_W]}}, s2_prod};
        ovr_wrap = ((acc_base[MAC_ACC_W-1 -: 8] == MAC_OVR_POS_TOP) &&
                    (next_acc_sum[MAC_ACC_W-1 -: 8] == MAC_OVR_NEG_TOP)) ||
                   ((acc_base[MAC_ACC_W-1 -: 8] == MAC_OVR_NEG_TOP) &&
                    (next_acc_sum[MAC_ACC_W-1 -: 8] == MAC_OVR_POS_TOP));
        next_flags[MAC_ST_N] = next_acc_sum[MAC_ACC_W-1];
        next_flags[MAC_ST_Z] = (next_acc_sum == '0);
        next_flags[MAC_ST_SO] =
            !((&next_acc_sum[MAC_ACC_W-1:MAC_SIGN_BIT]) ||
              !(|next_acc_sum[MAC_ACC_W-1:MAC_SIGN_BIT]));
        if (s2_clr) begin
            next_flags[MAC_ST_HO] = 1'b0;
        end else if (s2_ms) begin
            next_flags[MAC_ST_HO] = mac_status_flags[MAC_ST_HO];
        end else begin
            next_flags[MAC_ST_HO] =
                mac_status_flags[MAC_ST_HO] || ovr_wrap;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // accumulator: stage two beats shift beats clear beats software
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            acc <= '0;
        end else if (s2_valid) begin
            acc <= next_acc_sum;
        end else if (shift_now) begin
            if (mac_configuration[MAC_CF_SD]) begin
                acc <= {acc[MAC_ACC_W-1], acc[MAC_ACC_W-1:1]};
            end else begin
                acc <= {acc[MAC_ACC_W-2:0], 1'b0};
            end
        end else if (s1_clr) begin
            acc <= '0;
        end else if (sfr_wr) begin
            case (sfr_addr)
                MAC_ADDR_ACC_OVR: acc[39:32] <= sfr_wdata;
                MAC_ADDR_ACC_B3: acc[31:24] <= sfr_wdata;
                MAC_ADDR_ACC_B2: acc[23:16] <= sfr_wdata;
                MAC_ADDR_ACC_B1: acc[15:8] <= sfr_wdata;
                MAC_ADDR_ACC_B0: acc[7:0] <= sfr_wdata;
                default: acc <= acc;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status: hardware update wins over a software write in the same cycle
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            mac_status_flags <= MAC_ST_RESET;
        end else if (s2_valid) begin
            mac_status_flags <= next_flags;
        end else if (s1_clr) begin
            mac_status_flags <= '0;
        end else if (wr_st) begin
            mac_status_flags <= sfr_wdata[MAC_ST_W-1:0];
        end
    end
    // shifts have no path into the status register

    ////////////////////////////////////////////////////////////////////////
    // configuration and operands
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            mac_configuration <= MAC_CF_RESET;
        end else begin
            if (wr_cf) begin
                mac_configuration <= sfr_wdata[MAC_CF_W-1:0];
            end else begin
                if (shift_now) begin
                    mac_configuration[MAC_CF_SC] <= 1'b0;
                end
                if (s1_clr) begin
                    mac_configuration[MAC_CF_CA] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            operand_a <= '0;
            operand_b <= '0;
        end else if (sfr_wr) begin
            case (sfr_addr)
                MAC_ADDR_A_HIGH: operand_a[15:8] <= sfr_wdata;
                MAC_ADDR_A_LOW: operand_a[7:0] <= sfr_wdata;
                MAC_ADDR_B_HIGH: operand_b[15:8] <= sfr_wdata;
                MAC_ADDR_B_LOW: operand_b[7:0] <= sfr_wdata;
                default: operand_a <= operand_a;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // stage three: rounding engine, reads the accumulator and the saturation bit only
    logic rnd_up;
    logic signed [MAC_RSUM_W-1:0] rnd_sum;
    logic [MAC_RND_W-1:0] next_rnd;

    always_comb begin
        rnd_up = (acc[MAC_RND_LSB-1:0] > MAC_RND_HALF) ||
                 ((acc[MAC_RND_LSB-1:0] == MAC_RND_HALF) &&
                  acc[MAC_RND_LSB]);
        rnd_sum = $signed({acc[MAC_ACC_W-1], acc[MAC_ACC_W-1:MAC_RND_LSB]})
                  + $signed({{(MAC_RSUM_W-1){1'b0}}, rnd_up});
        next_rnd = rnd_sum[MAC_RND_W-1:0];
        if (mac_configuration[MAC_CF_SAT]) begin
            if (!rnd_sum[MAC_RSUM_W-1] &&
                (|rnd_sum[MAC_RSUM_W-2:MAC_RND_W-1])) begin
                next_rnd = MAC_SAT_POS;
            end else if (rnd_sum[MAC_RSUM_W-1] &&
                         !(&rnd_sum[MAC_RSUM_W-2:MAC_RND_W-1])) begin
                next_rnd = MAC_SAT_NEG;
            end
        end
    end

    // round one cycle after stage two, a shift or a byte0 write moved the accumulator
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rnd_pending <= 1'b0;
            rounding_result <= '0;
        end else begin
            rnd_pending <= s2_valid || shift_now || wr_acc0;
            if (rnd_pending) begin
                rounding_result <= next_rnd;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read port, no side effects
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            sfr_rdata <= '0;
        end else if (sfr_rd) begin
            case (sfr_addr)
                MAC_ADDR_CONFIG: sfr_rdata <= {2'h0, mac_configuration};
                MAC_ADDR_STATUS: sfr_rdata <= {4'h0, mac_status_flags};
                MAC_ADDR_A_HIGH: sfr_rdata <= operand_a[15:8];
                MAC_ADDR_A_LOW: sfr_rdata <= operand_a[7:0];
                MAC_ADDR_B_HIGH: sfr_rdata <= operand_b[15:8];
                MAC_ADDR_B_LOW: sfr_rdata <= operand_b[7:0];
                MAC_ADDR_ACC_OVR: sfr_rdata <= acc[39:32];
                MAC_ADDR_ACC_B3: sfr_rdata <= acc[31:24];
                MAC_ADDR_ACC_B2: sfr_rdata <= acc[23:16];
                MAC_ADDR_ACC_B1: sfr_rdata <= acc[15:8];
                MAC_ADDR_ACC_B0: sfr_rdata <= acc[7:0];
                MAC_ADDR_RND_HIGH: sfr_rdata <= rounding_result[15:8];
                MAC_ADDR_RND_LOW: sfr_rdata <= rounding_result[7:0];
                default: sfr_rdata <= 8'h00;
            endcase
        end
    end

endmodule : mac_engine

// ==== verification/mac_engine_chk.sv ====
// Purpose: port checks for the multiply-accumulate engine
// Assumes: one clock domain, asynchronous active-low reset
// Notes: bound onto mac_engine at the foot of this file
`timescale 1ns/100ps
module mac_engine_chk (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [mac_pkg::MAC_ADDR_W-1:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [mac_pkg::MAC_DATA_W-1:0] sfr_wdata,
    input wire logic [mac_pkg::MAC_DATA_W-1:0] sfr_rdata
);
    import mac_pkg::*;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    logic mapped;
    logic rd_cfg;
    logic rd_sta;
    logic wr_cfg;
    assign mapped = sfr_addr inside {MAC_ADDR_CONFIG, MAC_ADDR_STATUS,
        MAC_ADDR_A_HIGH, MAC_ADDR_A_LOW, MAC_ADDR_B_HIGH, MAC_ADDR_B_LOW,
        MAC_ADDR_ACC_OVR, MAC_ADDR_ACC_B3, MAC_ADDR_ACC_B2, MAC_ADDR_ACC_B1,
        MAC_ADDR_ACC_B0, MAC_ADDR_RND_HIGH, MAC_ADDR_RND_LOW};
    assign rd_cfg = sfr_rd && sfr_addr == MAC_ADDR_CONFIG;
    assign rd_sta = sfr_rd && sfr_addr == MAC_ADDR_STATUS;
    assign wr_cfg = sfr_wr && sfr_addr == MAC_ADDR_CONFIG;
    ////////////////////////////////////////////////////////////////////////
    a_rdata_holds: assert property (
        !sfr_rd |=> $stable(sfr_rdata)) else $error("read data moved");
    a_unmapped_zero: assert property (
        sfr_rd && !mapped |=> sfr_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_cfg_top_zero: assert property (
        rd_cfg |=> sfr_rdata[7:6] == 2'h0) else $error("config top bits");
    a_status_top_zero: assert property (
        rd_sta |=> sfr_rdata[7:4] == 4'h0) else $error("status top bits");
    a_opnd_readback: assert property (
        sfr_wr && sfr_addr == MAC_ADDR_A_HIGH ##1
        sfr_rd && sfr_addr == MAC_ADDR_A_HIGH
        |=> sfr_rdata == $past(sfr_wdata, 2)) else $error("operand readback");
    a_shift_selfclear: assert property (
        wr_cfg && sfr_wdata[MAC_CF_SC] ##2 rd_cfg |=> !sfr_rdata[MAC_CF_SC])
        else $error("shift bit stuck");
    a_clear_selfclear: assert property (
        wr_cfg && sfr_wdata[MAC_CF_CA] ##1
        sfr_wr && sfr_addr == MAC_ADDR_B_LOW ##2 rd_cfg
        |=> !sfr_rdata[MAC_CF_CA]) else $error("clear bit stuck");
    a_shift_flags: assert property (
        rd_sta ##2 wr_cfg && sfr_wdata[MAC_CF_SC] ##2 rd_sta
        |=> sfr_rdata == $past(sfr_rdata, 4)) else $error("shift hit flags");
    c_back_to_back: cover property (sfr_wr && sfr_addr == MAC_ADDR_B_LOW
        ##1 sfr_wr && sfr_addr == MAC_ADDR_B_LOW);
    c_shift: cover property (wr_cfg && sfr_wdata[MAC_CF_SC]);
    c_unmapped: cover property (sfr_rd && !mapped);
endmodule : mac_engine_chk

bind mac_engine mac_engine_chk mac_engine_chk_i (.clk_sys(clk_sys),
    .rst_b(rst_b), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata));

// ==== verification/mac_cpu_model.sv ====
// Purpose: processor-side model driving the byte register bus
// Assumes: requests change 1 ns after the rising edge
// Notes: tasks are called from the bench
`timescale 1ns/100ps
module mac_cpu_model (
    input wire logic clk_sys,
    output logic [mac_pkg::MAC_ADDR_W-1:0] sfr_addr,
    output logic sfr_wr,
    output logic sfr_rd,
    output logic [mac_pkg::MAC_DATA_W-1:0] sfr_wdata,
    input wire logic [mac_pkg::MAC_DATA_W-1:0] sfr_rdata
);
    import mac_pkg::*;
    initial begin
        sfr_addr = 8'h00;
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        sfr_wdata = 8'h00;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        #1;
        sfr_addr = a;
        sfr_wdata = d;
        sfr_rd = 1'b0;
        sfr_wr = 1'b1;
    endtask : wr
    task automatic idle(input int n);
        repeat (n) begin
            @(posedge clk_sys);
            #1;
            sfr_wr = 1'b0;
            sfr_rd = 1'b0;
            // released data inverted so stale bytes never pass
            sfr_wdata = ~sfr_wdata;
        end
    endtask : idle
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        #1;
        sfr_addr = a;
        sfr_wr = 1'b0;
        sfr_rd = 1'b1;
        idle(1);
        d = sfr_rdata;
    endtask : rd
endmodule : mac_cpu_model

// ==== verification/mac_engine_bench.sv ====
// Purpose: self-checking bench for the multiply-accumulate engine
// Assumes: registered read data one cycle after the strobe
// Notes: reference model kept in plain variables below
`timescale 1ns/100ps
module mac_engine_bench;
    import mac_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] sfr_addr;
    logic sfr_wr;
    logic sfr_rd;
    logic [7:0] sfr_wdata;
    logic [7:0] sfr_rdata;
    int mismatches = 0;
    int n_tests = 0;
    logic [39:0] acc = 40'h0;
    logic [3:0] st = MAC_ST_RESET;
    logic [7:0] d;
    bit sat;
    always #4 clk_sys = ~clk_sys;
    mac_engine mac_engine_i (.clk_sys, .rst_b, .sfr_addr, .sfr_wr, .sfr_rd,
        .sfr_wdata, .sfr_rdata);
    mac_cpu_model cpu (.clk_sys, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata,
        .sfr_rdata);
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    function automatic logic [15:0] rnd(input logic [39:0] a);
        logic [24:0] r;
        r = {a[39], a[39:16]} + 25'((a[15:0] > 16'h8000) ||
            (a[15:0] == 16'h8000 && a[16]));
        if (sat && r[24:15] != {10{r[24]}})
            return r[24] ? 16'h8000 : 16'h7fff;
        return r[15:0];
    endfunction : rnd
    task automatic chk_all();
        logic [7:0] ad [8];
        logic [63:0] ex;
        ad = '{MAC_ADDR_ACC_OVR, MAC_ADDR_ACC_B3, MAC_ADDR_ACC_B2,
            MAC_ADDR_ACC_B1, MAC_ADDR_ACC_B0, MAC_ADDR_RND_HIGH,
            MAC_ADDR_RND_LOW, MAC_ADDR_STATUS};
        ex = {acc, rnd(acc), 4'h0, st};
        for (int i = 0; i < 8; i++) begin
            cpu.rd(ad[i], d);
            chk(d, ex[63-8*i -: 8]);
        end
    endtask : chk_all
    task automatic op(input logic [7:0] cf, input logic [15:0] a,
        input logic [15:0] b, input int n);
        logic [39:0] p;
        logic [7:0] ov;
        cpu.wr(MAC_ADDR_A_HIGH, a[15:8]);
        cpu.wr(MAC_ADDR_A_LOW, a[7:0]);
        cpu.wr(MAC_ADDR_B_HIGH, b[15:8]);
        cpu.wr(MAC_ADDR_CONFIG, cf);
        repeat (n) cpu.wr(MAC_ADDR_B_LOW, b[7:0]);
        cpu.idle(1);
        cpu.rd(MAC_ADDR_CONFIG, d);
        chk(d, cf & 8'hf7);
        sat = cf[MAC_CF_SAT];
        p = 40'($signed(a) * $signed(b)) << cf[MAC_CF_FM];
        if (cf[MAC_CF_CA]) begin
            acc = 40'h0;
            st = 4'h0;
        end
        repeat (n) begin
            ov = acc[39:32];
            acc = (cf[MAC_CF_MS] ? 40'h0 : acc) + p;
            st[MAC_ST_HO] |= !cf[MAC_CF_MS] &&
                {ov, acc[39:32]} inside {16'h7f80, 16'h807f};
            st[MAC_ST_N] = acc[39];
            st[MAC_ST_Z] = acc == 40'h0;
            st[MAC_ST_SO] = acc[39:31] != 9'h0 && acc[39:31] != 9'h1ff;
        end
        chk_all();
    endtask : op
    task automatic load(input logic [39:0] v, input logic [7:0] cf);
        cpu.wr(MAC_ADDR_CONFIG, cf);
        for (int i = 4; i >= 0; i--) begin
            cpu.wr(MAC_ADDR_ACC_B0 + 8'(i), v[8*i +: 8]);
        end
        acc = v;
        sat = cf[MAC_CF_SAT];
        chk_all();
    endtask : load
    task automatic print_verdict();
        $display("mismatches %0d, comparisons %0d", mismatches, n_tests);
        if (mismatches == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : print_verdict
    // long stop only; every bus wait is already a fixed count
    // bound kept well above the cycle count of a run
    initial begin
        #600000;
        mismatches++;
        print_verdict();
    end
    initial begin
        void'($urandom(68040));
        repeat (5) @(posedge clk_sys);
        #1;
        rst_b = 1'b1;
        cpu.rd(MAC_ADDR_CONFIG, d);
        chk(d, {2'h0, MAC_CF_RESET});
        cpu.rd(MAC_ADDR_STATUS, d);
        chk(d, {4'h0, MAC_ST_RESET});
        cpu.rd(8'h10, d);
        chk(d, 8'h00);
        cpu.wr(MAC_ADDR_CONFIG, 8'hc7);
        cpu.wr(MAC_ADDR_A_HIGH, 8'h5a);
        cpu.rd(MAC_ADDR_A_HIGH, d);
        chk(d, 8'h5a);
        cpu.rd(MAC_ADDR_CONFIG, d);
        chk(d, 8'h07);
        repeat (60) op({4'h0, $urandom % 4 == 0, 3'($urandom)},
            16'($urandom), 16'($urandom), 1);
        repeat (4) op(8'h00, 16'($urandom), 16'($urandom), 2);
        cpu.wr(MAC_ADDR_STATUS, 8'h00);
        st = 4'h0;
        load(40'h7fffffffff, 8'h00);
        op(8'h00, 16'h0001, 16'h0001, 1);
        // hard overflow now set: multiply-only must leave it standing
        op(8'h01, 16'($urandom), 16'($urandom), 1);
        cpu.wr(MAC_ADDR_STATUS, 8'h00);
        st = 4'h0;
        repeat (12) load({8'($urandom), 32'($urandom)},
            {5'h0, 1'($urandom), 2'h0});
        load(40'h0000018000, 8'h00);
        load(40'h0000028000, 8'h00);
        load(40'h0100000000, 8'h04);
        load(40'hfe00000000, 8'h04);
        load(40'h4088442211, 8'h00);
        cpu.rd(MAC_ADDR_STATUS, d);
        cpu.wr(MAC_ADDR_CONFIG, 8'h20);
        cpu.idle(1);
        cpu.rd(MAC_ADDR_STATUS, d);
        chk(d, {4'h0, st});
        acc = acc << 1;
        chk_all();
        cpu.wr(MAC_ADDR_CONFIG, 8'h30);
        cpu.wr(MAC_ADDR_CONFIG, 8'h30);
        cpu.idle(1);
        cpu.rd(MAC_ADDR_CONFIG, d);
        chk(d, 8'h10);
        acc = {{2{acc[39]}}, acc[39:2]};
        chk_all();
        print_verdict();
    end
endmodule : mac_engine_bench
